// [rtl/tss_status_config.sv]
// Status and configuration logic of the temperature sensor: flags, alarm pins, conversion timing.
//
// Function
// - Under-limit flag bit 4, hysteretic or read clear
// - Over-limit flag bit 5, hysteretic or read clear
// - Critical flag bit 6, hysteretic or read clear
// - Ready bit 7 low on store, high on read
// - Mode write restores ready in one-shot, ONE_PER_SECOND_MODE
// - Config bits 1:0 set fault count 1 to 4
// - Config bit 2 sets critical pin polarity
// - Config bit 3 sets limit pin polarity
// - Config bit 4 selects comparator or interrupt
// - Mode 00 converts back to back continuously
// - Mode 01 performs one 240 ms conversion
// - Mode 10 converts 60 ms once per second
// - Mode 11 shuts down, registers stay accessible
// - Config bit 7 selects 13 or 16 bit
// - Low three result bits: data or flags
// - Hysteresis widens limits when leaving an alarm
`include "tss_cfg.svh"
`timescale 1ns/1ns
module tss_status_config
	import tss_pkg::*;
#(
	parameter int unsigned ONESHOT_CYC = `TSS_ONESHOT_MS * (`TSS_CLK_HZ / 1000),
	parameter int unsigned SPS_CONV_CYC = `TSS_SPS_CONV_MS * (`TSS_CLK_HZ / 1000),
	parameter int unsigned SPS_PERIOD_CYC = `TSS_SPS_PERIOD_MS * (`TSS_CLK_HZ / 1000),
	parameter int unsigned CONT_CONV_CYC = `TSS_CONT_CONV_MS * (`TSS_CLK_HZ / 1000)
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET_N,
	input  wire logic        CLK_EN,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic [15:0] ADC_SAMPLE,
	input  wire logic [15:0] HIGH_LIMIT,
	input  wire logic [15:0] LOW_LIMIT,
	input  wire logic [15:0] CRIT_LIMIT,
	input  wire logic [3:0]  HYSTERESIS_VALUE,
	output logic             ADC_POWER_EN,
	output logic             CONV_DONE,
	output logic             LIMIT_ALARM_PIN,
	output logic             CRITICAL_ALARM_PIN
);
	logic [7:0]  config_reg;
	logic [15:0] temp_reg;
	logic        low_flag_reg, high_flag_reg, crit_flag_reg, rdy_n_reg;
	logic        low_cond_reg, high_cond_reg, crit_cond_reg;
	logic        lim_irq_reg, crit_irq_reg;
	logic [2:0]  lim_cnt_reg, crit_cnt_reg;
	logic [31:0] timer_reg;
	tss_state_e  state_reg;
	logic        conv_end;
	logic        mode_wr;
	logic        st_rd;
	logic        temp_rd;
	tss_mode_e   mode;
	logic signed [16:0] t_s, hi_s, lo_s, cr_s, hy_s;
	logic        low_now, high_now, crit_now;
	logic        lim_fault, crit_fault;
	logic [2:0]  fq_depth;
	logic        lim_cmp, crit_cmp;
	logic [15:0] temp_shown;

	// One register access decode, shared by every side effect of the bus.
	function automatic logic bus_hit(input logic en, input logic strobe,
	                                 input logic [7:0] addr, input logic [7:0] target);
		return en && strobe && addr == target;
	endfunction

	// Only the timed modes restart the ready flag when their code is written.
	function automatic logic is_timed_start(input logic [1:0] code);
		return code == TSS_MODE_ONESHOT || code == TSS_MODE_ONE_SPS;
	endfunction

	assign mode    = tss_mode_e'(config_reg[`TSS_CFG_MODE_LSB +: 2]);
	assign st_rd   = bus_hit(CLK_EN, REG_RD, REG_ADDR, `TSS_ADDR_STATUS);
	assign temp_rd = bus_hit(CLK_EN, REG_RD, REG_ADDR, `TSS_ADDR_TEMP_LSB);
	assign mode_wr = bus_hit(CLK_EN, REG_WR, REG_ADDR, `TSS_ADDR_CONFIG);

	// Limits are compared in 16-bit units; hysteresis is whole degrees (128 LSB per degree).
	assign t_s  = {ADC_SAMPLE[15], ADC_SAMPLE};
	assign hi_s = {HIGH_LIMIT[15], HIGH_LIMIT};
	assign lo_s = {LOW_LIMIT[15], LOW_LIMIT};
	assign cr_s = {CRIT_LIMIT[15], CRIT_LIMIT};
	assign hy_s = {6'h00, HYSTERESIS_VALUE, 7'h00};

	// An alarm enters past the limit and leaves only past the hysteresis band.
	assign low_now  = low_cond_reg ? (t_s <= lo_s + hy_s) : (t_s < lo_s);
	assign high_now = high_cond_reg ? (t_s >= hi_s - hy_s) : (t_s > hi_s);
	assign crit_now = crit_cond_reg ? (t_s >= cr_s - hy_s) : (t_s > cr_s);

	// Conversion sequencer: timer runs in CONV, and WAIT pads ONE_PER_SECOND_MODE to one second.
	assign conv_end = state_reg == TSS_ST_CONV && timer_reg == 32'h0;

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			// The first conversion after reset runs a full continuous period.
			state_reg <= TSS_ST_CONV;
			timer_reg <= 32'(CONT_CONV_CYC - 1);
		end else if (CLK_EN) begin
			if (mode_wr) begin
				unique case (tss_mode_e'(REG_WDATA[`TSS_CFG_MODE_LSB +: 2]))
					TSS_MODE_CONT: begin
						state_reg <= TSS_ST_CONV;
						timer_reg <= CONT_CONV_CYC - 1;
					end
					TSS_MODE_ONESHOT: begin
						state_reg <= TSS_ST_CONV;
						timer_reg <= ONESHOT_CYC - 1;
					end
					TSS_MODE_ONE_SPS: begin
						state_reg <= TSS_ST_CONV;
						timer_reg <= SPS_CONV_CYC - 1;
					end
					TSS_MODE_SHUTDOWN: begin
						state_reg <= TSS_ST_IDLE;
						timer_reg <= 32'h0;
					end
				endcase
			end else begin
				unique case (state_reg)
					TSS_ST_IDLE: timer_reg <= 32'h0;
					TSS_ST_CONV: begin
						if (timer_reg != 32'h0) begin
							timer_reg <= timer_reg - 32'h1;
						end else if (mode == TSS_MODE_CONT) begin
							timer_reg <= CONT_CONV_CYC - 1;
						end else if (mode == TSS_MODE_ONE_SPS) begin
							state_reg <= TSS_ST_WAIT;
							timer_reg <= SPS_PERIOD_CYC - SPS_CONV_CYC - 1;
						end else begin
							state_reg <= TSS_ST_IDLE;
						end
					end
					TSS_ST_WAIT: begin
						if (timer_reg != 32'h0) begin
							timer_reg <= timer_reg - 32'h1;
						end else begin
							state_reg <= TSS_ST_CONV;
							timer_reg <= SPS_CONV_CYC - 1;
						end
					end
					default: state_reg <= TSS_ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			config_reg <= `TSS_CFG_RESET;
		end else if (mode_wr) begin
			config_reg <= REG_WDATA;
		end
	end

	// Result store; 13-bit mode zeroes the three low result bits.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			temp_reg      <= 16'h0000;
			low_cond_reg  <= 1'b0;
			high_cond_reg <= 1'b0;
			crit_cond_reg <= 1'b0;
		end else if (CLK_EN && conv_end) begin
			temp_reg      <= config_reg[`TSS_CFG_RES_BIT] ? ADC_SAMPLE
			                 : {ADC_SAMPLE[15:3], 3'h0};
			low_cond_reg  <= low_now;
			high_cond_reg <= high_now;
			crit_cond_reg <= crit_now;
		end
	end

	// Status flags: a new event in the read cycle wins over the read clear.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			low_flag_reg  <= 1'b0;
			high_flag_reg <= 1'b0;
			crit_flag_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (conv_end) begin
				low_flag_reg  <= low_now || (low_flag_reg && !st_rd && low_now);
				high_flag_reg <= high_now;
				crit_flag_reg <= crit_now;
			end else if (st_rd) begin
				low_flag_reg  <= 1'b0;
				high_flag_reg <= 1'b0;
				crit_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdy_n_reg <= 1'b1;
		end else if (CLK_EN) begin
			if (conv_end) begin
				rdy_n_reg <= 1'b0;
			end else if (temp_rd) begin
				rdy_n_reg <= 1'b1;
			end else if (mode_wr && is_timed_start(REG_WDATA[`TSS_CFG_MODE_LSB +: 2])) begin
				rdy_n_reg <= 1'b1;
			end
		end
	end

	// Fault queues count consecutive violating conversions, saturating one past the deepest code.
	function automatic logic [2:0] fq_next(input logic [2:0] cnt, input logic hit);
		if (!hit) begin
			return 3'h0;
		end
		return (cnt == 3'h4) ? cnt : cnt + 3'h1;
	endfunction

	assign fq_depth   = {1'b0, config_reg[`TSS_CFG_FQ_LSB +: 2]};
	assign lim_fault  = lim_cnt_reg >= fq_depth;
	assign crit_fault = crit_cnt_reg >= fq_depth;
	// Comparator pins need depth plus one consecutive faults, like the latched path.
	assign lim_cmp    = (low_cond_reg || high_cond_reg) && lim_cnt_reg > fq_depth;
	assign crit_cmp   = crit_cond_reg && crit_cnt_reg > fq_depth;

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lim_cnt_reg <= 3'h0;
		end else if (CLK_EN && conv_end) begin
			lim_cnt_reg <= fq_next(lim_cnt_reg, low_now || high_now);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			crit_cnt_reg <= 3'h0;
		end else if (CLK_EN && conv_end) begin
			crit_cnt_reg <= fq_next(crit_cnt_reg, crit_now);
		end
	end

	// Latched alarms: a new fault in the read cycle wins over the read clear.
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lim_irq_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (conv_end && (low_now || high_now) && lim_fault) begin
				lim_irq_reg <= 1'b1;
			end else if (st_rd) begin
				lim_irq_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			crit_irq_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (conv_end && crit_now && crit_fault) begin
				crit_irq_reg <= 1'b1;
			end else if (st_rd) begin
				crit_irq_reg <= 1'b0;
			end
		end
	end

	assign temp_shown = config_reg[`TSS_CFG_RES_BIT] ? temp_reg
	                    : {temp_reg[15:3], crit_flag_reg, high_flag_reg, low_flag_reg};

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA          <= 8'h00;
			ADC_POWER_EN       <= 1'b1;
			CONV_DONE          <= 1'b0;
			LIMIT_ALARM_PIN    <= 1'b1;
			CRITICAL_ALARM_PIN <= 1'b1;
		end else if (CLK_EN) begin
			unique case (REG_ADDR)
				`TSS_ADDR_TEMP_MSB: REG_RDATA <= temp_shown[15:8];
				`TSS_ADDR_TEMP_LSB: REG_RDATA <= temp_shown[7:0];
				`TSS_ADDR_STATUS:   REG_RDATA <= {rdy_n_reg, crit_flag_reg, high_flag_reg,
				                                  low_flag_reg, 4'h0};
				`TSS_ADDR_CONFIG:   REG_RDATA <= config_reg;
				default:            REG_RDATA <= 8'h00;
			endcase
			ADC_POWER_EN       <= state_reg == TSS_ST_CONV;
			CONV_DONE          <= conv_end;
			LIMIT_ALARM_PIN    <= ~config_reg[`TSS_CFG_LIM_POL_BIT] ^
			                      (config_reg[`TSS_CFG_CMP_BIT]
			                       ? lim_cmp
			                       : lim_irq_reg);
			CRITICAL_ALARM_PIN <= ~config_reg[`TSS_CFG_CRIT_POL_BIT] ^
			                      (config_reg[`TSS_CFG_CMP_BIT]
			                       ? crit_cmp
			                       : crit_irq_reg);
		end
	end
endmodule // tss_status_config

// [rtl/tss_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the sensor status block.
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH
`define TSS_ADDR_TEMP_MSB    8'h00
`define TSS_ADDR_TEMP_LSB    8'h01
`define TSS_ADDR_STATUS      8'h02
`define TSS_ADDR_CONFIG      8'h03
`define TSS_ST_LOW_BIT       4
`define TSS_ST_HIGH_BIT      5
`define TSS_ST_CRIT_BIT      6
`define TSS_ST_RDY_N_BIT     7
`define TSS_CFG_RESET        8'h00
`define TSS_CFG_FQ_LSB       0
`define TSS_CFG_CRIT_POL_BIT 2
`define TSS_CFG_LIM_POL_BIT  3
`define TSS_CFG_CMP_BIT      4
`define TSS_CFG_MODE_LSB     5
`define TSS_CFG_RES_BIT      7
`define TSS_CLK_HZ           50000000
`define TSS_ONESHOT_MS       240
`define TSS_SPS_CONV_MS      60
`define TSS_SPS_PERIOD_MS    1000
`define TSS_CONT_CONV_MS     240
`endif

// [rtl/tss_pkg.sv]
// Types shared by the sensor status block.
package tss_pkg;
	typedef enum logic [1:0] {
		TSS_MODE_CONT     = 2'b00,
		TSS_MODE_ONESHOT  = 2'b01,
		TSS_MODE_ONE_SPS  = 2'b10,
		TSS_MODE_SHUTDOWN = 2'b11
	} tss_mode_e;
	typedef enum logic [1:0] {
		TSS_ST_IDLE = 2'b00,
		TSS_ST_CONV = 2'b01,
		TSS_ST_WAIT = 2'b10
	} tss_state_e;
endpackage

// [tb/tss_status_monitor.sv]
// Concurrent checks on the ports of the sensor status block.
`timescale 1ns/1ns
module tss_status_monitor (
	input wire logic       CORE_CLK,
	input wire logic       RESET_N,
	input wire logic       CLK_EN,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic       ADC_POWER_EN,
	input wire logic       CONV_DONE,
	input wire logic       LIMIT_ALARM_PIN
);
	logic [7:0] cfg_reg;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N)
			cfg_reg <= 8'h00;
		else if (CLK_EN && REG_WR && REG_ADDR == 8'h03)
			cfg_reg <= REG_WDATA;
	end
	chk_cfg_readback: assert property ((CLK_EN && REG_ADDR == 8'h03 && !REG_WR)
		|=> REG_RDATA == $past(cfg_reg)) else $error("config readback differs");
	chk_unmapped_zero: assert property ((CLK_EN && REG_ADDR > 8'h03)
		|=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
	chk_status_unused: assert property ((CLK_EN && REG_ADDR == 8'h02)
		|=> REG_RDATA[3:0] == 4'h0) else $error("unused status bits set");
	chk_read_clears: assert property ((CLK_EN && REG_RD && REG_ADDR == 8'h02)
		##1 (CLK_EN && !CONV_DONE) ##1 (CLK_EN && REG_ADDR == 8'h02 && !CONV_DONE)
		|=> REG_RDATA[6:4] == 3'b000) else $error("flags survive status read");
	chk_ready_restore: assert property ((CLK_EN && REG_RD && REG_ADDR == 8'h01)
		##1 (CLK_EN && !CONV_DONE) ##1 (CLK_EN && REG_ADDR == 8'h02 && !CONV_DONE)
		|=> REG_RDATA[7]) else $error("ready not restored by result read");
	chk_ready_on_store: assert property ((CONV_DONE && CLK_EN && REG_ADDR == 8'h02
		&& !REG_RD && !$past(REG_RD) && !REG_WR && !$past(REG_WR))
		|=> !REG_RDATA[7]) else $error("ready not low after store");
	chk_done_pulse: assert property ((CONV_DONE && CLK_EN)
		|=> !CONV_DONE [*8]) else $error("result store pulse too long");
	chk_shutdown_off: assert property ((CLK_EN && cfg_reg[6:5] == 2'b11 && !ADC_POWER_EN)
		|=> !ADC_POWER_EN) else $error("converter powered in shutdown");
	chk_freeze_state: assert property (!CLK_EN |=> $stable(REG_RDATA) && $stable(CONV_DONE)
		&& $stable(ADC_POWER_EN) && $stable(LIMIT_ALARM_PIN)) else $error("state moved while frozen");
endmodule // tss_status_monitor
bind tss_status_config tss_status_monitor i_tss_status_monitor (.CORE_CLK(CORE_CLK),
	.RESET_N(RESET_N), .CLK_EN(CLK_EN), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.ADC_POWER_EN(ADC_POWER_EN), .CONV_DONE(CONV_DONE), .LIMIT_ALARM_PIN(LIMIT_ALARM_PIN));

// [tb/tss_host_model.sv]
// Register access model of the serial bus controller facing the block.
`timescale 1ns/1ns
module tss_host_model (
	input  wire logic       CORE_CLK,
	output logic            REG_WR,
	output logic            REG_RD,
	output logic [7:0]      REG_ADDR,
	output logic [7:0]      REG_WDATA,
	input  wire logic [7:0] REG_RDATA
);
	initial begin
		REG_WR = 0;
		REG_RD = 0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
	end
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CORE_CLK) #2;
		REG_ADDR = a;
		REG_WDATA = v;
		REG_WR = 1;
		@(posedge CORE_CLK) #2;
		REG_WR = 0;
		// Released data shows the inverse so a stale byte cannot pass.
		REG_WDATA = ~v;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge CORE_CLK) #2;
		REG_ADDR = a;
		REG_RD = 1;
		@(posedge CORE_CLK) #2;
		v = REG_RDATA;
		REG_RD = 0;
	endtask
endmodule // tss_host_model

// [tb/temp_sensor_status_config_test.sv]
// Self-checking bench of the sensor status block.
`timescale 1ns/1ns
module temp_sensor_status_config_test;
	logic        CORE_CLK = 0, RESET_N = 0, CLK_EN = 1;
	logic        REG_WR, REG_RD, ADC_POWER_EN, CONV_DONE, LIMIT_ALARM_PIN, CRITICAL_ALARM_PIN;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, d, e;
	logic [15:0] ADC_SAMPLE = 16'h0800;
	logic [15:0] hi_lim = 16'h2000, lo_lim = 16'h0500, cr_lim = 16'h4980;
	logic [3:0]  hyst = 4'h5;
	int          bad_count = 0, n_compared = 0, t, n;
	always #10 CORE_CLK = ~CORE_CLK;
	tss_host_model i_tss_host_model (.CORE_CLK(CORE_CLK), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA));
	tss_status_config #(.ONESHOT_CYC(20), .SPS_CONV_CYC(10), .SPS_PERIOD_CYC(40),
		.CONT_CONV_CYC(10)) i_tss_status_config (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
		.CLK_EN(CLK_EN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ADC_SAMPLE(ADC_SAMPLE),
		.HIGH_LIMIT(hi_lim), .LOW_LIMIT(lo_lim), .CRIT_LIMIT(cr_lim),
		.HYSTERESIS_VALUE(hyst), .ADC_POWER_EN(ADC_POWER_EN), .CONV_DONE(CONV_DONE),
		.LIMIT_ALARM_PIN(LIMIT_ALARM_PIN), .CRITICAL_ALARM_PIN(CRITICAL_ALARM_PIN));
	function automatic logic [7:0] exp_st(int v);
		return {1'b0, v > 'h4980, v > 'h2000, v < 'h0500, 4'h0};
	endfunction
	task wrap_up;
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(string nm, logic [7:0] e, logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask
	task wait_done;
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge CORE_CLK) #2;
			if (CONV_DONE === 1'b1) break;
		end
		if (i == 200) begin
			chk("conv_done", 8'h01, 8'h00);
			wrap_up;
		end
	endtask
	task count_done(int cyc);
		n = 0;
		repeat (cyc) @(posedge CORE_CLK) #2 n += (CONV_DONE === 1'b1);
	endtask
	task pins(logic [1:0] e);
		@(posedge CORE_CLK) #2;
		chk("pins", {6'h0, e}, {6'h0, LIMIT_ALARM_PIN, CRITICAL_ALARM_PIN});
	endtask
	initial begin
		void'($urandom(32'h2094));
		repeat (2) @(posedge CORE_CLK);
		#2 RESET_N = 1;
		pins(2'b11);
		i_tss_host_model.rd(8'h02, d); chk("status", 8'h80, d);
		i_tss_host_model.rd(8'h03, d); chk("config", 8'h00, d);
		i_tss_host_model.rd(8'h0b, d); chk("unmapped", 8'h00, d);
		t = 'h0800 + $urandom % 'h1000;
		ADC_SAMPLE = t[15:0];
		wait_done; wait_done;
		i_tss_host_model.rd(8'h02, d); chk("status", exp_st(t), d);
		for (int k = 0; k < 2; k++) begin
			t = k ? 'h5000 : 'h3000;
			ADC_SAMPLE = t[15:0];
			e = exp_st(t);
			wait_done;
			pins({1'b0, t < 'h4980});
			i_tss_host_model.rd(8'h01, d); chk("flags", {5'h0, e[6:4]}, {5'h0, d[2:0]});
			i_tss_host_model.rd(8'h02, d); chk("status", e | 8'h80, d);
			i_tss_host_model.rd(8'h02, d); chk("cleared", 8'h80, d);
			pins(2'b11);
		end
		i_tss_host_model.wr(8'h03, 8'h1c);
		ADC_SAMPLE = 16'h5000;
		wait_done; pins(2'b11);
		ADC_SAMPLE = 16'h0800;
		wait_done; wait_done; pins(2'b00);
		i_tss_host_model.wr(8'h03, 8'h13);
		ADC_SAMPLE = 16'h0100;
		repeat (3) wait_done;
		pins(2'b11);
		wait_done; pins(2'b01);
		i_tss_host_model.wr(8'h03, 8'h20);
		i_tss_host_model.rd(8'h02, d); chk("ready", 8'h01, {7'h0, d[7]});
		wait_done; count_done(60); chk("one-shot", 8'h00, n[7:0]);
		chk("power", 8'h00, {7'h0, ADC_POWER_EN});
		i_tss_host_model.wr(8'h03, 8'h40);
		wait_done; count_done(60); chk("sps", 8'h01, n[7:0]);
		i_tss_host_model.wr(8'h03, 8'h60);
		count_done(60); chk("shutdown", 8'h00, n[7:0]);
		i_tss_host_model.rd(8'h03, d); chk("config", 8'h60, d);
		i_tss_host_model.wr(8'h03, 8'h80);
		ADC_SAMPLE = 16'h0805;
		repeat (40) @(posedge CORE_CLK) #2 CLK_EN = $urandom % 2;
		CLK_EN = 1;
		wait_done; wait_done;
		i_tss_host_model.rd(8'h01, d); chk("fine", 8'h05, {5'h0, d[2:0]});
		wrap_up;
	end
endmodule // temp_sensor_status_config_test
